//--- rtl/lars_pkg.sv
// lars_pkg: constants shared by the linear array readout sequencer
// assumes a single 50 MHz clock domain and no software-visible registers
package lars_pkg;

    // ----------------------------------------------------------------
    // array geometry
    // ----------------------------------------------------------------
    localparam int PIXELS = 128;              // token stages and pixels
    localparam int IDX_W = 7;                 // pixel index width
    localparam int PIX_W = 8;                 // held pixel value width
    localparam int WORD_W = IDX_W + PIX_W;    // stream word: index and value
    localparam int FIFO_DEPTH = 8;            // words buffered on the stream

    // ----------------------------------------------------------------
    // sequencing counts
    // ----------------------------------------------------------------
    localparam int RESET_CLKS = 18;           // integrator reset clocks
    localparam int END_EDGE = 129;            // edge on which the token leaves
    localparam int CYC_W = 8;                 // cycle counter width

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;        // 50 MHz clock
    localparam int CHARGE_TRANSFER_TIME_US = 20;
    localparam int CHARGE_TRANSFER_CYCLES =
        (CHARGE_TRANSFER_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int XFER_W = 11;               // counter width for the above

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [PIX_W-1:0] PIX_RESET = 8'h00;
    localparam logic [PIXELS-1:0] TOKEN_RESET = '0;
    localparam logic [PIX_W-1:0] PIX_MAX = 8'hff;

endpackage

//--- rtl/lars_fifo.sv
// lars_fifo: small synchronous FIFO with valid/ready on both sides
// assumes one clock; storage is flip-flops addressed by an index
`timescale 1ns/1ps
`default_nettype none

module lars_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,                 // clock
    input wire logic rst_i,                 // async reset, active high
    input wire logic in_valid_i,            // writer offers a word
    output logic in_ready_o,                // room for a word
    input wire logic [WIDTH-1:0] in_data_i, // word in
    output logic out_valid_o,               // a word is waiting
    input wire logic out_ready_i,           // reader takes the word
    output logic [WIDTH-1:0] out_data_o     // oldest word
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push;
    wire pop;

    // ----------------------------------------------------------------
    // flags from the occupancy count
    // ----------------------------------------------------------------
    assign in_ready_o = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != '0);
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    assign out_data_o = mem_q[rd_q];

    // pointers wrap on depth, which need not be a power of two
    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
        wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    // ----------------------------------------------------------------
    // storage and pointers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= wrap_inc(wr_q);
            if (pop)
                rd_q <= wrap_inc(rd_q);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // data array needs no reset; it is never read while empty
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_q[wr_q] <= in_data_i;
    end

endmodule

`default_nettype wire

//--- rtl/lars_seq.sv
// lars_seq: token sequencer, hold logic and pixel readout of a 128 pixel array
// assumes the start strobe and light inputs are synchronous to clk_i;
// the pixel output is a tri-state pin given as value plus low-active enable
`timescale 1ns/1ps
`default_nettype none

module lars_seq (
    input wire logic clk_i,                                   // 50 MHz clock
    input wire logic rst_i,                                   // async reset, active high
    input wire logic start_i,                                 // serial start strobe
    input wire logic [lars_pkg::PIXELS-1:0] light_i,          // photocurrent per pixel
    output logic [lars_pkg::PIX_W-1:0] analog_pixel_output_o, // pixel value on the pin
    output logic analog_pixel_output_oe_n_o,                  // low while pin is driven
    output logic hold_o,                                      // freeze pulse to samplers
    output logic integ_reset_o,                               // integrators held in reset
    output logic busy_o,                                      // output cycle running
    output logic transfer_done_o,                             // charge transfer time over
    output logic stream_valid_o,                              // buffered pixel waiting
    input wire logic stream_ready_i,                          // reader takes pixel
    output logic [lars_pkg::WORD_W-1:0] stream_data_o,        // {index, value}
    output logic stream_in_ready_o,                           // buffer has room
    output logic overrun_o                                    // pixel lost, buffer full
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        LARS_IDLE,
        LARS_OUTPUT,
        LARS_XFER
    } lars_state_t;

    lars_state_t state_q;
    lars_state_t state_d;
    logic [lars_pkg::PIXELS-1:0] token_q;
    logic [lars_pkg::PIXELS-1:0] token_d;
    logic [lars_pkg::PIX_W-1:0] integ_q [lars_pkg::PIXELS];
    logic [lars_pkg::PIX_W-1:0] sample_q [lars_pkg::PIXELS];
    logic [lars_pkg::CYC_W-1:0] cyc_q;
    logic [lars_pkg::CYC_W-1:0] cyc_d;
    logic [lars_pkg::XFER_W-1:0] xfer_q;
    logic [lars_pkg::XFER_W-1:0] xfer_d;
    logic start_prev_q;
    logic [lars_pkg::PIX_W-1:0] pix_q;
    logic [lars_pkg::PIX_W-1:0] pix_d;
    logic [lars_pkg::IDX_W-1:0] idx_q;
    logic oe_n_q;
    logic hold_q;
    logic push_q;
    logic overrun_q;

    // one-hot token to pixel index
    function automatic logic [lars_pkg::IDX_W-1:0] token_index(
        input logic [lars_pkg::PIXELS-1:0] t);
        logic [lars_pkg::IDX_W-1:0] r;
        r = '0;
        for (int i = 0; i < lars_pkg::PIXELS; i++)
        begin
            if (t[i])
                r = lars_pkg::IDX_W'(i);
        end
        token_index = r;
    endfunction

    // ----------------------------------------------------------------
    // start detection and token movement
    // ----------------------------------------------------------------
    // edge detect keeps a strobe held too long from restarting the cycle
    wire start_edge = start_i & ~start_prev_q;
    // a strobe inside a running cycle is ignored so the token stays one-hot
    wire start_take = start_edge & (state_q != LARS_OUTPUT);
    wire token_last = token_q[lars_pkg::PIXELS-1];
    wire in_output = (token_d != lars_pkg::TOKEN_RESET);
    wire integ_rst = (cyc_q != '0) &&
        (cyc_q <= lars_pkg::CYC_W'(lars_pkg::RESET_CLKS));
    wire [lars_pkg::IDX_W-1:0] idx_d = token_index(token_d);

    // token enters stage 0 on the start edge, leaves after the last stage
    assign token_d = start_take ? lars_pkg::PIXELS'(1)
                                : {token_q[lars_pkg::PIXELS-2:0], 1'b0};

    // ----------------------------------------------------------------
    // next state and counters
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        cyc_d = cyc_q;
        xfer_d = xfer_q;
        case (state_q)
            LARS_IDLE:
            begin
                if (start_take)
                begin
                    state_d = LARS_OUTPUT;
                    cyc_d = lars_pkg::CYC_W'(1);
                end
            end
            LARS_OUTPUT:
            begin
                // counts edges up to and including the closing 129th
                if (cyc_q < lars_pkg::CYC_W'(lars_pkg::END_EDGE))
                    cyc_d = cyc_q + lars_pkg::CYC_W'(1);
                if (token_last)
                begin
                    state_d = LARS_XFER;
                    xfer_d = '0;
                end
            end
            LARS_XFER:
            begin
                cyc_d = '0;
                if (start_take)
                begin
                    state_d = LARS_OUTPUT;
                    cyc_d = lars_pkg::CYC_W'(1);
                end
                else if (xfer_q == lars_pkg::XFER_W'(lars_pkg::CHARGE_TRANSFER_CYCLES))
                    state_d = LARS_IDLE;
                else
                    xfer_d = xfer_q + lars_pkg::XFER_W'(1);
            end
            default:
            begin
                state_d = LARS_IDLE;
                cyc_d = '0;
                xfer_d = '0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // pixel value for the coming clock period
    // ----------------------------------------------------------------
    // on the start edge the sample is being taken, so read the integrator
    assign pix_d = !in_output ? lars_pkg::PIX_RESET :
                   start_take ? integ_q[0] : sample_q[idx_d];

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    // sequencing state: phase, token and the two counters
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q <= LARS_IDLE;
            token_q <= lars_pkg::TOKEN_RESET;
            cyc_q <= '0;
            xfer_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            token_q <= token_d;
            cyc_q <= cyc_d;
            xfer_q <= xfer_d;
        end
    end

    // strobe history and the one-clock freeze pulse
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            start_prev_q <= 1'b0;
            hold_q <= 1'b0;
        end
        else
        begin
            start_prev_q <= start_i;
            hold_q <= start_take;
        end
    end

    // ----------------------------------------------------------------
    // output pin and stream push
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pix_q <= lars_pkg::PIX_RESET;
            idx_q <= '0;
            oe_n_q <= 1'b1;
            push_q <= 1'b0;
        end
        else
        begin
            pix_q <= pix_d;
            idx_q <= idx_d;
            oe_n_q <= ~in_output;
            push_q <= in_output;
        end
    end

    // ----------------------------------------------------------------
    // integrators and sampling capacitors
    // ----------------------------------------------------------------
    // counters saturate rather than wrap, as a charge well would
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < lars_pkg::PIXELS; i++)
            begin
                integ_q[i] <= lars_pkg::PIX_RESET;
            end
        end
        else
        begin
            for (int i = 0; i < lars_pkg::PIXELS; i++)
            begin
                if (integ_rst)
                    integ_q[i] <= lars_pkg::PIX_RESET;
                else if (light_i[i] && integ_q[i] != lars_pkg::PIX_MAX)
                    integ_q[i] <= integ_q[i] + lars_pkg::PIX_W'(1);
            end
        end
    end

    // all capacitors load on one edge, so every pixel shares one exposure
    // window; a start refused mid-cycle leaves the held line untouched
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < lars_pkg::PIXELS; i++)
            begin
                sample_q[i] <= lars_pkg::PIX_RESET;
            end
        end
        else if (start_take)
        begin
            for (int i = 0; i < lars_pkg::PIXELS; i++)
            begin
                sample_q[i] <= integ_q[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // pixel stream buffer
    // ----------------------------------------------------------------
    // the array cannot stall its token, so a full buffer drops the word
    // and latches overrun; stream_in_ready_o lets the reader see it coming
    logic fifo_in_ready;

    lars_fifo #(
        .WIDTH(lars_pkg::WORD_W),
        .DEPTH(lars_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(push_q),
        .in_ready_o(fifo_in_ready),
        .in_data_i({idx_q, pix_q}),
        .out_valid_o(stream_valid_o),
        .out_ready_i(stream_ready_i),
        .out_data_o(stream_data_o)
    );

    // sticky until the next accepted start strobe
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            overrun_q <= 1'b0;
        else if (push_q && !fifo_in_ready)
            overrun_q <= 1'b1;
        else if (start_take)
            overrun_q <= 1'b0;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign analog_pixel_output_o = pix_q;
    assign analog_pixel_output_oe_n_o = oe_n_q;
    assign hold_o = hold_q;
    assign integ_reset_o = integ_rst;
    assign busy_o = (state_q == LARS_OUTPUT);
    assign transfer_done_o = (state_q == LARS_IDLE);
    assign stream_in_ready_o = fifo_in_ready;
    assign overrun_o = overrun_q;

endmodule

`default_nettype wire

//--- dv/lars_seq_chk.sv
// lars_seq_chk: timing assertions on the readout sequencer's pins
// assumes it is bound to lars_seq; one clock, async active high reset
`timescale 1ns/1ps
`default_nettype none

module lars_seq_chk (
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic start_i, // start strobe
    input wire logic [lars_pkg::PIX_W-1:0] analog_pixel_output_o, // pin value
    input wire logic analog_pixel_output_oe_n_o, // pin enable, low active
    input wire logic hold_o, // freeze pulse
    input wire logic integ_reset_o, // integrator reset
    input wire logic busy_o, // cycle running
    input wire logic transfer_done_o, // transfer wait over
    input wire logic stream_valid_o, // word waiting
    input wire logic stream_ready_i, // reader ready
    input wire logic [lars_pkg::WORD_W-1:0] stream_data_o, // oldest word
    input wire logic stream_in_ready_o, // room left
    input wire logic overrun_o // word dropped
);
    // ----------------------------------------------------------------
    // cycle position, 1 on the cycle after an accepted start
    // ----------------------------------------------------------------
    logic prev_q;
    logic [7:0] pos_q;
    wire acc = start_i && !prev_q && !busy_o;
    wire in_out = pos_q >= 8'h01 && pos_q <= 8'h80;

    // saturates so a long idle spell never wraps back into the window
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            prev_q <= 1'b0;
            pos_q <= 8'h00;
        end
        else
        begin
            prev_q <= start_i;
            pos_q <= acc ? 8'h01 : (pos_q == 8'h00 || pos_q == 8'hff) ? pos_q : pos_q + 8'h01;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    start_takes_a: assert property (
        acc |=> hold_o && busy_o && !analog_pixel_output_oe_n_o) else $error("start not taken");
    hold_cause_a: assert property (
        hold_o |-> $past(acc) && !$past(hold_o)) else $error("stray hold pulse");
    integ_len_a: assert property (
        pos_q != 8'h00 |-> integ_reset_o == (pos_q <= 8'h12)) else $error("reset span wrong");
    drive_span_a: assert property (
        analog_pixel_output_oe_n_o == !in_out) else $error("pin enable span wrong");
    busy_span_a: assert property (
        busy_o == in_out) else $error("busy span wrong");
    tail_edge_a: assert property (
        $fell(analog_pixel_output_oe_n_o) |-> ##128 $rose(analog_pixel_output_oe_n_o))
        else $error("pin not released on last edge");
    idle_zero_a: assert property (
        analog_pixel_output_oe_n_o |-> analog_pixel_output_o == 8'h00)
        else $error("idle pin not 0");
    tx_wait_a: assert property (
        $rose(analog_pixel_output_oe_n_o) |-> !transfer_done_o [*8]) else $error("transfer early");
    stream_hold_a: assert property (
        stream_valid_o && !stream_ready_i |=> stream_valid_o && $stable(stream_data_o))
        else $error("stalled word moved");
    overrun_set_a: assert property (
        $rose(overrun_o) |-> !$past(stream_in_ready_o)) else $error("overrun without full");
endmodule

`default_nettype wire

//--- dv/lars_ctrl_model.sv
// lars_ctrl_model: readout controller issuing start strobes
// assumes the bench supplies clk_i and calls strobe hierarchically
`timescale 1ns/1ps
`default_nettype none

module lars_ctrl_model (
    input wire logic clk_i, // clock from the bench
    output logic start_o // start strobe
);
    int since = lars_pkg::END_EDGE;

    initial start_o = 1'b0;

    // edges since the last strobe, paces the next one
    always @(posedge clk_i)
    begin
        since <= start_o ? 0 : since + 1;
    end

    // one clock long; a stray strobe skips pacing to poke a running cycle
    task automatic strobe(input bit stray);
        begin
            while (!stray && since < lars_pkg::END_EDGE)
            begin
                @(posedge clk_i);
            end
            @(posedge clk_i);
            start_o <= 1'b1;
            @(posedge clk_i);
            start_o <= 1'b0;
        end
    endtask
endmodule

`default_nettype wire

//--- dv/tb.sv
// tb: self-checking scenarios for the readout sequencer
// assumes lars_pkg, lars_seq, lars_fifo, the model and checker compiled first
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) \
        begin \
            bad_count++; \
            $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); \
        end \
    end

module tb;
    // ----------------------------------------------------------------
    // signals, clock and instances
    // ----------------------------------------------------------------
    localparam logic [127:0] PAT_A = 128'h6666_6666_6666_6666_6666_6666_6666_6666;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic start_i;
    logic [lars_pkg::PIXELS-1:0] light_i = PAT_A;
    logic stream_ready_i = 1'b1;
    logic [lars_pkg::PIX_W-1:0] pin;
    logic pin_oe_n, hold_o, integ_reset_o, busy_o, transfer_done_o;
    logic stream_valid_o, stream_in_ready_o, overrun_o;
    logic [lars_pkg::WORD_W-1:0] stream_data_o;
    logic [lars_pkg::PIXELS-1:0] exp_lit;
    int bad_count = 0;
    int cmp_count = 0;
    int nwords;

    // core clock fixed at 50 MHz; a slower pin clock only stretches each step
    always #(lars_pkg::CLK_PERIOD_NS / 2) clk_i = ~clk_i;

    lars_ctrl_model ctrl (.clk_i(clk_i), .start_o(start_i));

    lars_seq uut (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .light_i(light_i),
        .analog_pixel_output_o(pin), .analog_pixel_output_oe_n_o(pin_oe_n), .hold_o(hold_o),
        .integ_reset_o(integ_reset_o), .busy_o(busy_o), .transfer_done_o(transfer_done_o),
        .stream_valid_o(stream_valid_o), .stream_ready_i(stream_ready_i),
        .stream_data_o(stream_data_o), .stream_in_ready_o(stream_in_ready_o),
        .overrun_o(overrun_o));

    // lit pixels saturate, dark ones stay at the cleared level
    function automatic logic [7:0] px(input int k);
        return exp_lit[k] ? lars_pkg::PIX_MAX : lars_pkg::PIX_RESET;
    endfunction

    task automatic end_of_test;
        begin
            $display("compares %0d mismatches %0d", cmp_count, bad_count);
            if (bad_count == 0 && cmp_count > 0)
            begin
                $display("Result: passed");
            end
            else
            begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask

    // pops are judged in index order as they happen
    task automatic look;
        begin
            if (stream_valid_o === 1'b1 && stream_ready_i === 1'b1)
            begin
                `CHK(stream_data_o, {nwords[6:0], px(nwords)})
                nwords++;
            end
        end
    endtask

    task automatic idle_check;
        begin
            `CHK(pin_oe_n, 1'b1)
            `CHK(busy_o, 1'b0)
            `CHK(transfer_done_o, 1'b1)
            `CHK(stream_valid_o, 1'b0)
        end
    endtask

    // one output cycle; a stray strobe mid-cycle must be ignored
    task automatic frame(input logic [127:0] lit, input logic [127:0] nxt, input bit stall);
        int k;
        int n;
        begin
            exp_lit = lit;
            nwords = 0;
            ctrl.strobe(1'b0);
            light_i <= nxt;
            stream_ready_i <= !stall;
            #1;
            for (k = 0; k < lars_pkg::PIXELS; k++)
            begin
                `CHK(pin_oe_n, 1'b0)
                `CHK(pin, px(k))
                `CHK(integ_reset_o, 1'(k < lars_pkg::RESET_CLKS))
                `CHK(hold_o, 1'(k == 0))
                `CHK(busy_o, 1'b1)
                if (k == 40 && !stall)
                    fork
                        ctrl.strobe(1'b1);
                    join_none
                look();
                @(posedge clk_i);
                #1;
            end
            `CHK(pin_oe_n, 1'b1)
            `CHK(pin, 8'h00)
            `CHK(busy_o, 1'b0)
            if (!stall)
            begin
                n = 0;
                while (transfer_done_o !== 1'b1 && n < 2000)
                begin
                    look();
                    @(posedge clk_i);
                    #1;
                    n++;
                end
                `CHK(n, lars_pkg::CHARGE_TRANSFER_CYCLES + 1)
                `CHK(nwords, lars_pkg::PIXELS)
            end
        end
    endtask

    // full buffer drained, then a start during the transfer wait
    task automatic drain_restart;
        int i;
        begin
            `CHK(overrun_o, 1'b1)
            `CHK(stream_in_ready_o, 1'b0)
            `CHK(transfer_done_o, 1'b0)
            @(posedge clk_i);
            stream_ready_i <= 1'b1;
            #1;
            for (i = 0; i < lars_pkg::FIFO_DEPTH; i++)
            begin
                `CHK(stream_valid_o, 1'b1)
                `CHK(stream_data_o, {i[6:0], px(i)})
                @(posedge clk_i);
                #1;
            end
            `CHK(stream_valid_o, 1'b0)
            ctrl.strobe(1'b0);
            #1;
            `CHK(overrun_o, 1'b0)
            `CHK(hold_o, 1'b1)
            repeat (lars_pkg::END_EDGE - 1) @(posedge clk_i);
            #1;
            `CHK(pin_oe_n, 1'b1)
        end
    endtask

    // watchdog, well beyond the few thousand cycles the run needs
    initial
    begin
        #(lars_pkg::CLK_PERIOD_NS * 20000);
        bad_count++;
        end_of_test();
    end

    initial
    begin
        repeat (19) @(posedge clk_i);
        #1;
        idle_check();
        @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (300) @(posedge clk_i);
        frame(PAT_A, ~PAT_A, 1'b0);
        frame(~PAT_A, PAT_A, 1'b0);
        frame(PAT_A, PAT_A, 1'b1);
        drain_restart();
        end_of_test();
    end
endmodule

bind lars_seq lars_seq_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i),
    .analog_pixel_output_o(analog_pixel_output_o), .hold_o(hold_o),
    .analog_pixel_output_oe_n_o(analog_pixel_output_oe_n_o), .busy_o(busy_o),
    .integ_reset_o(integ_reset_o), .transfer_done_o(transfer_done_o),
    .stream_valid_o(stream_valid_o), .stream_ready_i(stream_ready_i),
    .stream_data_o(stream_data_o), .stream_in_ready_o(stream_in_ready_o),
    .overrun_o(overrun_o));

`default_nettype wire
